// ===== tb/lgrc_eeprom_model.sv
`timescale 1ns/1ps
module lgrc_eeprom_model (
  // serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o
);
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] addr_r = 8'h00;
  logic [4:0] cnt_r = 5'h00;
  logic [7:0] byte_v;
  // pointer byte holds an offset above 5fh, the rest a simple pattern
  function automatic logic [7:0] rom_byte(input logic [7:0] a);
    return (a == 8'h28) ? 8'h6a : (a ^ 8'h5c);
  endfunction : rom_byte
  initial miso_o = 1'b0;
  // command then address, msb first, on rising sck
  always @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_r <= 5'h00;
    end else begin
      if (cnt_r < 5'h08) cmd_r <= {cmd_r[6:0], mosi_i};
      else if (cnt_r < 5'h10) addr_r <= {addr_r[6:0], mosi_i};
      cnt_r <= cnt_r + 5'h01;
    end
  end
  // data moves on falling sck; outside the data phase the line toggles
  always @(negedge sck_i or posedge cs_n_i) begin
    byte_v = rom_byte(addr_r);
    if (!cs_n_i && cnt_r >= 5'h10 && cnt_r < 5'h18 && cmd_r == 8'h03)
      miso_o <= byte_v[5'h17 - cnt_r];
    else
      miso_o <= ~miso_o;
  end
endmodule : lgrc_eeprom_model

// ===== tb/lgrc_regs_bench.sv
`timescale 1ns/1ps
module lgrc_regs_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  logic arvalid_i = 1'b0, rready_i = 1'b0, id_rom_present_i = 1'b1;
  logic cs_load_i = 1'b0, cs_done_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, cs_value_i = 32'h0;
  logic [3:0] wstrb_i = 4'h0;
  logic [2:0] tx_start_i = 3'h0, tx_ack_valid_i = 3'h0;
  logic [11:0] tx_ack_code_i = 12'h000;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, rom_miso_i;
  logic rom_cs_n_o, rom_sck_o, rom_mosi_o;
  logic [1:0] bresp_o, rresp_o, cs_select_o, got_resp;
  logic [31:0] rdata_o, got_data;
  logic [2:0] tx_retry_o, tx_done_o;
  logic [11:0] tx_final_ack_o;
  int n_mismatch = 0, checks_done = 0;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] wr;
    logic [31:0] rd;
    logic [1:0] rr;
  } lgrc_row_t;
  localparam logic [1:0] ERR = lgrc_pkg::RESP_SLVERR;
  lgrc_row_t rows [5] = '{
    '{8'h08, 32'hffffffff, 4'hf, 2'h0, 32'h00000fff, 2'h0},
    '{8'h08, 32'h00000a53, 4'h2, 2'h0, 32'h00000aff, 2'h0},
    '{8'h00, 32'hffffffff, 4'hf, 2'h0, 32'h01000000, 2'h0},
    '{8'h40, 32'hffffffff, 4'hf, ERR, 32'h00000000, ERR},
    '{8'h14, 32'h00000002, 4'hf, 2'h0, 32'h00000002, 2'h0}
  };
  // the last go comes with a clear, so it must fetch byte zero again
  logic [31:0] go_word [3] = '{32'h02000000, 32'h02000000, 32'h82000000};
  logic [7:0] go_byte [3] = '{8'h5c, 8'h5d, 8'h5c};
  logic [7:0] zero_ofs [3] = '{8'h04, 8'h00, 8'h08};

  lgrc_regs i_dut (.clk_i, .sys_rst_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i,
    .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
    .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .id_rom_present_i, .rom_miso_i,
    .rom_cs_n_o, .rom_sck_o, .rom_mosi_o, .tx_start_i, .tx_ack_valid_i, .tx_ack_code_i,
    .tx_retry_o, .tx_done_o, .tx_final_ack_o, .cs_load_i, .cs_value_i, .cs_done_i,
    .cs_select_o);
  lgrc_eeprom_model i_rom (.cs_n_i(rom_cs_n_o), .sck_i(rom_sck_o), .mosi_i(rom_mosi_o),
    .miso_o(rom_miso_i));

  always #25 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // judged on the answer itself, so a late answer on the last try still counts
  task automatic tmo(input logic seen);
    if (seen !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: answer missing", $time);
      give_verdict();
    end
  endtask : tmo

  task automatic do_reset(input logic p);
    id_rom_present_i <= p;
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (pa && awready_o) begin
        pa = 1'b0;
        awvalid_i <= 1'b0;
      end
      if (pw && wready_o) begin
        pw = 1'b0;
        wvalid_i <= 1'b0;
      end
    end while (!bvalid_o && n < 60);
    got_resp = bresp_o;
    bready_i <= 1'b0;
    tmo(bvalid_o);
    @(posedge clk_i);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready_o) arvalid_i <= 1'b0;
    end while (!rvalid_o && n < 60);
    got_data = rdata_o;
    got_resp = rresp_o;
    rready_i <= 1'b0;
    tmo(rvalid_o);
    @(posedge clk_i);
  endtask : axi_rd

  // start a packet, answer each attempt with code, expect lim retries then done
  task automatic tx_run(input int u, input int lim, input logic [3:0] code);
    int n;
    tx_start_i[u] <= 1'b1;
    @(posedge clk_i);
    tx_start_i[u] <= 1'b0;
    for (int k = 0; k <= lim; k++) begin
      tx_ack_code_i[4*u +: 4] <= code;
      tx_ack_valid_i[u] <= 1'b1;
      @(posedge clk_i);
      tx_ack_valid_i[u] <= 1'b0;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (!(tx_retry_o[u] || tx_done_o[u]) && n < 5);
      tmo(tx_retry_o[u] || tx_done_o[u]);
      chk({30'h0, tx_retry_o[u], tx_done_o[u]}, (k < lim) ? 32'h2 : 32'h1, "retry");
    end
    chk({28'h0, tx_final_ack_o[4*u +: 4]}, {28'h0, code}, "final ack");
  endtask : tx_run

  // polling is slow but keeps to the register view software has
  task automatic rom_poll(input int b);
    int n;
    n = 0;
    do begin
      axi_rd(lgrc_pkg::ROM_ACCESS_OFS);
      n++;
    end while (got_data[b] !== 1'b0 && n < 200);
    tmo(got_data[b] === 1'b0);
    chk({31'h0, got_data[b]}, 32'h0, "self clear");
  endtask : rom_poll

  initial begin
    do_reset(1'b1);
    axi_rd(lgrc_pkg::RETRY_OFS);
    chk(got_data, 32'h0, "retry reset");
    tx_run(0, 0, lgrc_pkg::ACK_BUSY_X);
    for (int i = 0; i < 5; i++) begin
      axi_wr(rows[i].a, rows[i].d, rows[i].s);
      chk({30'h0, got_resp}, {30'h0, rows[i].wr}, "bresp");
      axi_rd(rows[i].a);
      chk(got_data, rows[i].rd, "rdata");
      chk({30'h0, got_resp}, {30'h0, rows[i].rr}, "rresp");
    end
    axi_wr(lgrc_pkg::RETRY_OFS, 32'h00000213, 4'hf);
    tx_run(0, 3, lgrc_pkg::ACK_BUSY_A);
    tx_run(1, 1, lgrc_pkg::ACK_DATA_ERROR);
    tx_run(2, 2, lgrc_pkg::ACK_BUSY_B);
    tx_run(2, 0, 4'h1);
    repeat (400) @(posedge clk_i);
    axi_rd(lgrc_pkg::ROM_ACCESS_OFS);
    chk(got_data, 32'h0000006a, "option pointer");
    axi_wr(lgrc_pkg::ROM_ACCESS_OFS, 32'h80000000, 4'h8);
    rom_poll(31);
    chk(got_data, 32'h0000006a, "no fetch");
    for (int i = 0; i < 3; i++) begin
      axi_wr(lgrc_pkg::ROM_ACCESS_OFS, go_word[i], 4'h8);
      rom_poll(25);
      chk(got_data, {8'h00, go_byte[i], 16'h006a}, "rom byte");
    end
    cs_value_i <= 32'h13579bdf;
    cs_load_i <= 1'b1;
    @(posedge clk_i);
    cs_load_i <= 1'b0;
    axi_wr(lgrc_pkg::CS_VALUE_OFS, 32'hffffffff, 4'hf);
    axi_rd(lgrc_pkg::CS_VALUE_OFS);
    chk(got_data, 32'h13579bdf, "swap value");
    cs_done_i <= 1'b1;
    @(posedge clk_i);
    cs_done_i <= 1'b0;
    axi_rd(lgrc_pkg::CS_CTRL_OFS);
    chk(got_data, 32'h80000002, "done set");
    chk({30'h0, cs_select_o}, 32'h2, "select");
    axi_wr(lgrc_pkg::CS_CTRL_OFS, 32'h00000001, 4'hf);
    axi_rd(lgrc_pkg::CS_CTRL_OFS);
    chk(got_data, 32'h00000001, "done clear");
    do_reset(1'b0);
    axi_wr(lgrc_pkg::ROM_ACCESS_OFS, 32'h02000000, 4'h8);
    repeat (8) @(posedge clk_i);
    chk({31'h0, rom_cs_n_o}, 32'h1, "no frame");
    for (int i = 0; i < 3; i++) begin
      axi_rd(zero_ofs[i]);
      chk(got_data, 32'h0, "absent rom");
    end
    give_verdict();
  end
endmodule : lgrc_regs_bench

// ===== tb/lgrc_regs_properties.sv
`timescale 1ns/1ps
module lgrc_regs_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register bus
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // eeprom pins
  input wire logic id_rom_present_i,
  input wire logic rom_cs_n_o,
  input wire logic rom_sck_o,
  // transmit units
  input wire logic [2:0] tx_start_i,
  input wire logic [2:0] tx_ack_valid_i,
  input wire logic [2:0] tx_retry_o,
  input wire logic [2:0] tx_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [8:0] low_cnt_r;
  logic [8:0] low_cnt_nxt;
  logic rom_wr;
  // frame length counter, wide enough to see a stuck select
  always_comb low_cnt_nxt = rom_cs_n_o ? 9'h000 : low_cnt_r + 9'h001;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) low_cnt_r <= 9'h000;
    else low_cnt_r <= low_cnt_nxt;
  end
  assign rom_wr = awvalid_i && awready_o && wvalid_i && wready_o
    && awaddr_i == lgrc_pkg::ROM_ACCESS_OFS;
  a_sck_idle_low:
    assert property (rom_cs_n_o |-> !rom_sck_o) else $error("sck high while deselected");
  a_sck_half_period:
    assert property ($rose(rom_sck_o) |-> rom_sck_o [*4] ##1 !rom_sck_o)
    else $error("sck half period wrong");
  a_frame_length:
    assert property ($rose(rom_cs_n_o) |-> low_cnt_r inside {[9'd188:9'd200]})
    else $error("rom frame length wrong");
  a_frame_bound:
    assert property (!rom_cs_n_o |-> low_cnt_r < 9'd200) else $error("rom frame too long");
  a_go_starts_frame:
    assert property (rom_wr && wstrb_i[3] && wdata_i[25] && !wdata_i[31] && id_rom_present_i
      && rom_cs_n_o |-> ##[1:4] !rom_cs_n_o) else $error("read go did not start a frame");
  a_clear_no_fetch:
    assert property (rom_wr && wdata_i[31] && !wdata_i[25] && rom_cs_n_o
      |=> rom_cs_n_o [*8]) else $error("address clear started a fetch");
  a_req_ack_result:
    assert property (tx_ack_valid_i[0] && !tx_start_i[0] |=> tx_retry_o[0] != tx_done_o[0])
    else $error("request ack gave no single result");
  a_phys_ack_result:
    assert property (tx_ack_valid_i[2] && !tx_start_i[2] |=> tx_retry_o[2] != tx_done_o[2])
    else $error("phys ack gave no single result");
  a_resp_result_cause:
    assert property (tx_retry_o[1] || tx_done_o[1] |-> $past(tx_ack_valid_i[1]))
    else $error("response result without ack");
  c_frame: cover property ($rose(rom_cs_n_o));
  c_retry: cover property (tx_retry_o[0]);
  c_done: cover property (tx_done_o[2]);
endmodule : lgrc_regs_properties

bind lgrc_regs lgrc_regs_properties i_props (.clk_i, .sys_rst_i, .awvalid_i, .awready_o,
  .awaddr_i, .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .id_rom_present_i, .rom_cs_n_o, .rom_sck_o,
  .tx_start_i, .tx_ack_valid_i, .tx_retry_o, .tx_done_o);

// ===== verilog/lgrc_pkg.sv
package lgrc_pkg;
  // register byte offsets
  localparam logic [7:0] VERSION_OFS = 8'h00;
  localparam logic [7:0] ROM_ACCESS_OFS = 8'h04;
  localparam logic [7:0] RETRY_OFS = 8'h08;
  localparam logic [7:0] CS_VALUE_OFS = 8'h0c;
  localparam logic [7:0] CS_CTRL_OFS = 8'h14;
  // id rom access fields
  localparam int ROM_CLEAR_BIT = 31;
  localparam int ROM_GO_BIT = 25;
  localparam int ROM_BYTE_LSB = 16;
  localparam int ROM_PTR_LSB = 0;
  localparam int ROM_PRESENT_BIT = 24;
  // retry limit fields
  localparam int PHYS_RETRY_LSB = 8;
  localparam int RESP_RETRY_LSB = 4;
  localparam int REQ_RETRY_LSB = 0;
  localparam logic [3:0] RETRY_RESET = 4'h0;
  // compare-swap control fields
  localparam int CS_DONE_BIT = 31;
  localparam logic [1:0] CS_SEL_RESET = 2'h0;
  // eeprom access
  localparam logic [7:0] ROM_READ_CMD = 8'h03;
  localparam logic [7:0] OPTION_PTR_ADDR = 8'h28;
  localparam logic [7:0] OPTION_PTR_RESET = 8'h00;
  localparam logic [2:0] ROM_HALF_CYC = 3'h4;
  localparam logic [4:0] ROM_TX_BITS = 5'h10;
  localparam logic [4:0] ROM_LAST_BIT = 5'h17;
  // acknowledge codes that allow a retry
  localparam logic [3:0] ACK_BUSY_X = 4'h4;
  localparam logic [3:0] ACK_BUSY_A = 4'h5;
  localparam logic [3:0] ACK_BUSY_B = 4'h6;
  localparam logic [3:0] ACK_DATA_ERROR = 4'hd;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ROM_IDLE = 2'b00,
    ROM_SHIFT = 2'b01
  } lgrc_rom_state_t;
endpackage : lgrc_pkg

// ===== verilog/lgrc_regs.sv
// Operation
// - address clear zeroes rom address, self clears
// - no automatic byte fetch after clear
// - read go starts fetch at current address
// - read go self clears when fetch ends
// - fetched byte lands in read byte field
// - reserved rom access bits read zero
// - option rom pointer resets to zero
// - option pointer loaded from eeprom byte 28h
// - seconds limit field reads zero
// - cycle limit field reads zero
// - nibble 15-12 of retry reads zero
// - physical response retries up to its limit
// - async response retries up to its limit
// - async request retries up to its limit
// - retry limits reset to zero
// - compare-swap value register read only
// - rom access only with rom present
// - done flag set, cleared on control write
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module lgrc_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // serial eeprom pins
  input wire logic id_rom_present_i,
  input wire logic rom_miso_i,
  output logic rom_cs_n_o,
  output logic rom_sck_o,
  output logic rom_mosi_o,
  // transmit units: bit 0 request, 1 response, 2 physical response
  input wire logic [2:0] tx_start_i,
  input wire logic [2:0] tx_ack_valid_i,
  input wire logic [11:0] tx_ack_code_i,
  output logic [2:0] tx_retry_o,
  output logic [2:0] tx_done_o,
  output logic [11:0] tx_final_ack_o,
  // compare-swap engine
  input wire logic cs_load_i,
  input wire logic [31:0] cs_value_i,
  input wire logic cs_done_i,
  output logic [1:0] cs_select_o
);
  // pin synchronisers
  logic [1:0] present_sync_r, miso_sync_r;
  logic [1:0] settle_r;
  logic present;
  logic miso;
  // axi state
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_hit;
  // register contents
  logic [3:0] req_lim_r, req_lim_nxt, resp_lim_r, resp_lim_nxt, phys_lim_r, phys_lim_nxt;
  logic [31:0] cs_value_r, cs_value_nxt;
  logic cs_done_r, cs_done_nxt;
  logic [1:0] cs_sel_r, cs_sel_nxt;
  logic clear_r, clear_nxt, go_r, go_nxt;
  logic [7:0] rom_byte_r, rom_byte_nxt, rom_ptr_r, rom_ptr_nxt;
  logic [7:0] rom_addr_r, rom_addr_nxt;
  logic boot_pend_r, boot_pend_nxt, boot_r, boot_nxt;
  // eeprom engine
  lgrc_pkg::lgrc_rom_state_t st_r, st_nxt;
  logic [2:0] div_r, div_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic cs_n_r, cs_n_nxt, sck_r, sck_nxt, mosi_r, mosi_nxt;

  // first stage is read only by the second
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      present_sync_r <= 2'h0;
      miso_sync_r <= 2'h0;
      settle_r <= 2'h0;
    end else begin
      present_sync_r <= {present_sync_r[0], id_rom_present_i};
      miso_sync_r <= {miso_sync_r[0], rom_miso_i};
      settle_r <= {settle_r[0], 1'b1};
    end
  end
  assign present = present_sync_r[1];
  assign miso = miso_sync_r[1];

  // read decode
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (araddr_i)
      lgrc_pkg::VERSION_OFS: rd_word[lgrc_pkg::ROM_PRESENT_BIT] = present;
      lgrc_pkg::ROM_ACCESS_OFS: begin
        if (present) begin
          rd_word[lgrc_pkg::ROM_CLEAR_BIT] = clear_r;
          rd_word[lgrc_pkg::ROM_GO_BIT] = go_r;
          rd_word[lgrc_pkg::ROM_BYTE_LSB +: 8] = rom_byte_r;
          rd_word[lgrc_pkg::ROM_PTR_LSB +: 8] = rom_ptr_r;
        end
        // other bits left zero
      end
      lgrc_pkg::RETRY_OFS: begin
        // upper fields stay zero
        rd_word[lgrc_pkg::PHYS_RETRY_LSB +: 4] = phys_lim_r;
        rd_word[lgrc_pkg::RESP_RETRY_LSB +: 4] = resp_lim_r;
        rd_word[lgrc_pkg::REQ_RETRY_LSB +: 4] = req_lim_r;
      end
      lgrc_pkg::CS_VALUE_OFS: rd_word = cs_value_r;
      lgrc_pkg::CS_CTRL_OFS: begin
        rd_word[lgrc_pkg::CS_DONE_BIT] = cs_done_r;
        rd_word[1:0] = cs_sel_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // bus slave and register file
  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt = w_have_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    req_lim_nxt = req_lim_r;
    resp_lim_nxt = resp_lim_r;
    phys_lim_nxt = phys_lim_r;
    cs_value_nxt = cs_value_r;
    cs_done_nxt = cs_done_r;
    cs_sel_nxt = cs_sel_r;
    if (awvalid_i && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = awaddr_i;
    end
    if (wvalid_i && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = wdata_i;
      wstrb_nxt = wstrb_i;
    end
    if (bvalid_r && bready_i) begin
      bvalid_nxt = 1'b0;
    end
    wr_fire = aw_have_r && w_have_r && !bvalid_r;
    if (cs_load_i) begin
      cs_value_nxt = cs_value_i;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = lgrc_pkg::RESP_OKAY;
      case (aw_addr_r)
        lgrc_pkg::RETRY_OFS: begin
          if (wstrb_r[1]) begin
            phys_lim_nxt = wdata_r[lgrc_pkg::PHYS_RETRY_LSB +: 4];
          end
          if (wstrb_r[0]) begin
            resp_lim_nxt = wdata_r[lgrc_pkg::RESP_RETRY_LSB +: 4];
            req_lim_nxt = wdata_r[lgrc_pkg::REQ_RETRY_LSB +: 4];
          end
        end
        lgrc_pkg::CS_CTRL_OFS: begin
          cs_done_nxt = 1'b0;
          if (wstrb_r[0]) begin
            cs_sel_nxt = wdata_r[1:0];
          end
        end
        lgrc_pkg::VERSION_OFS, lgrc_pkg::ROM_ACCESS_OFS, lgrc_pkg::CS_VALUE_OFS: begin
          // read-only words, or set bits handled in the eeprom engine
        end
        default: bresp_nxt = lgrc_pkg::RESP_SLVERR;
      endcase
    end
    // set wins over the clear from a control write
    if (cs_done_i) begin
      cs_done_nxt = 1'b1;
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt = !w_have_nxt;
    if (rvalid_r && rready_i) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid_i && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? lgrc_pkg::RESP_OKAY : lgrc_pkg::RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= lgrc_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= lgrc_pkg::RESP_OKAY;
      req_lim_r <= lgrc_pkg::RETRY_RESET;
      resp_lim_r <= lgrc_pkg::RETRY_RESET;
      phys_lim_r <= lgrc_pkg::RETRY_RESET;
      cs_value_r <= 32'h0;
      cs_done_r <= 1'b0;
      cs_sel_r <= lgrc_pkg::CS_SEL_RESET;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r <= w_have_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      req_lim_r <= req_lim_nxt;
      resp_lim_r <= resp_lim_nxt;
      phys_lim_r <= phys_lim_nxt;
      cs_value_r <= cs_value_nxt;
      cs_done_r <= cs_done_nxt;
      cs_sel_r <= cs_sel_nxt;
    end
  end

  // eeprom engine: read command, address, then one data byte, msb first
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    cs_n_nxt = cs_n_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    clear_nxt = clear_r;
    go_nxt = go_r;
    rom_byte_nxt = rom_byte_r;
    rom_ptr_nxt = rom_ptr_r;
    rom_addr_nxt = rom_addr_r;
    boot_pend_nxt = boot_pend_r;
    boot_nxt = boot_r;
    case (st_r)
      lgrc_pkg::ROM_IDLE: begin
        if (clear_r) begin
          rom_addr_nxt = 8'h00;
          clear_nxt = 1'b0;
        end else if (boot_pend_r && settle_r[1]) begin
          boot_pend_nxt = 1'b0;
          if (present) begin
            boot_nxt = 1'b1;
            st_nxt = lgrc_pkg::ROM_SHIFT;
            tx_nxt = {lgrc_pkg::ROM_READ_CMD, lgrc_pkg::OPTION_PTR_ADDR};
          end
        end else if (go_r) begin
          st_nxt = lgrc_pkg::ROM_SHIFT;
          tx_nxt = {lgrc_pkg::ROM_READ_CMD, rom_addr_r};
        end
        if (st_nxt == lgrc_pkg::ROM_SHIFT) begin
          cs_n_nxt = 1'b0;
          mosi_nxt = tx_nxt[15];
          div_nxt = 3'h0;
          bit_nxt = 5'h0;
        end
      end
      lgrc_pkg::ROM_SHIFT: begin
        div_nxt = div_r + 3'h1;
        if (div_r == lgrc_pkg::ROM_HALF_CYC - 3'h1) begin
          div_nxt = 3'h0;
          if (!sck_r) begin
            sck_nxt = 1'b1;
            if (bit_r >= lgrc_pkg::ROM_TX_BITS) begin
              rx_nxt = {rx_r[6:0], miso};
            end
          end else begin
            sck_nxt = 1'b0;
            bit_nxt = bit_r + 5'h1;
            tx_nxt = {tx_r[14:0], 1'b0};
            mosi_nxt = tx_r[14];
            if (bit_r == lgrc_pkg::ROM_LAST_BIT) begin
              st_nxt = lgrc_pkg::ROM_IDLE;
              cs_n_nxt = 1'b1;
              mosi_nxt = 1'b0;
              if (boot_r) begin
                boot_nxt = 1'b0;
                rom_ptr_nxt = rx_r;
              end else begin
                rom_byte_nxt = rx_r;
                go_nxt = 1'b0;
                rom_addr_nxt = rom_addr_r + 8'h01;
              end
            end
          end
        end
      end
      default: st_nxt = lgrc_pkg::ROM_IDLE;
    endcase
    // software set wins over the engine's own clear; ignored without a rom
    if (wr_fire && (aw_addr_r == lgrc_pkg::ROM_ACCESS_OFS) && wstrb_r[3] && present) begin
      if (wdata_r[lgrc_pkg::ROM_CLEAR_BIT]) begin
        clear_nxt = 1'b1;
      end
      if (wdata_r[lgrc_pkg::ROM_GO_BIT]) begin
        go_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= lgrc_pkg::ROM_IDLE;
      div_r <= 3'h0;
      bit_r <= 5'h0;
      tx_r <= 16'h0;
      rx_r <= 8'h00;
      cs_n_r <= 1'b1;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      clear_r <= 1'b0;
      go_r <= 1'b0;
      rom_byte_r <= 8'h00;
      rom_ptr_r <= lgrc_pkg::OPTION_PTR_RESET;
      rom_addr_r <= 8'h00;
      boot_pend_r <= 1'b1;
      boot_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      cs_n_r <= cs_n_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      clear_r <= clear_nxt;
      go_r <= go_nxt;
      rom_byte_r <= rom_byte_nxt;
      rom_ptr_r <= rom_ptr_nxt;
      rom_addr_r <= rom_addr_nxt;
      boot_pend_r <= boot_pend_nxt;
      boot_r <= boot_nxt;
    end
  end

  // one retry counter per transmit unit
  lgrc_retry_unit u_req (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .limit_i(req_lim_r),
    .start_i(tx_start_i[0]),
    .ack_valid_i(tx_ack_valid_i[0]),
    .ack_code_i(tx_ack_code_i[3:0]),
    .retry_o(tx_retry_o[0]),
    .done_o(tx_done_o[0]),
    .final_ack_o(tx_final_ack_o[3:0])
  );
  lgrc_retry_unit u_resp (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .limit_i(resp_lim_r),
    .start_i(tx_start_i[1]),
    .ack_valid_i(tx_ack_valid_i[1]),
    .ack_code_i(tx_ack_code_i[7:4]),
    .retry_o(tx_retry_o[1]),
    .done_o(tx_done_o[1]),
    .final_ack_o(tx_final_ack_o[7:4])
  );
  lgrc_retry_unit u_phys (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .limit_i(phys_lim_r),
    .start_i(tx_start_i[2]),
    .ack_valid_i(tx_ack_valid_i[2]),
    .ack_code_i(tx_ack_code_i[11:8]),
    .retry_o(tx_retry_o[2]),
    .done_o(tx_done_o[2]),
    .final_ack_o(tx_final_ack_o[11:8])
  );

  assign awready_o = awready_r;
  assign wready_o = wready_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;
  assign rom_cs_n_o = cs_n_r;
  assign rom_sck_o = sck_r;
  assign rom_mosi_o = mosi_r;
  assign cs_select_o = cs_sel_r;
endmodule : lgrc_regs

// ===== verilog/lgrc_retry_unit.sv
`timescale 1ns/1ps
module lgrc_retry_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // configuration
  input wire logic [3:0] limit_i,
  // packet events
  input wire logic start_i,
  input wire logic ack_valid_i,
  input wire logic [3:0] ack_code_i,
  // results
  output logic retry_o,
  output logic done_o,
  output logic [3:0] final_ack_o
);
  logic [3:0] cnt_r, cnt_nxt;
  logic retry_r, retry_nxt;
  logic done_r, done_nxt;
  logic [3:0] ack_r, ack_nxt;
  logic retryable;

  always_comb begin
    retryable = (ack_code_i == lgrc_pkg::ACK_BUSY_X) || (ack_code_i == lgrc_pkg::ACK_BUSY_A) ||
                (ack_code_i == lgrc_pkg::ACK_BUSY_B) || (ack_code_i == lgrc_pkg::ACK_DATA_ERROR);
    cnt_nxt = cnt_r;
    retry_nxt = 1'b0;
    done_nxt = 1'b0;
    ack_nxt = ack_r;
    if (start_i) begin
      cnt_nxt = 4'h0;
    end else if (ack_valid_i) begin
      if (retryable && (cnt_r < limit_i)) begin
        cnt_nxt = cnt_r + 4'h1;
        retry_nxt = 1'b1;
      end else begin
        done_nxt = 1'b1;
        ack_nxt = ack_code_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 4'h0;
      retry_r <= 1'b0;
      done_r <= 1'b0;
      ack_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
      retry_r <= retry_nxt;
      done_r <= done_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign retry_o = retry_r;
  assign done_o = done_r;
  assign final_ack_o = ack_r;
endmodule : lgrc_retry_unit
